// File: core/icpc_combiner.sv
// integrator chop pulse combiner: registers, pulse index and signed sum
// assumes pulses arrive one at a time tagged with their slot, and that
// a new sample per slot starts only after the previous one completed
`timescale 1ns/10ps
module icpc_combiner
  import icpc_pkg::*;
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  // register port
  input  wire icpc_pkg::icpc_reg_req_s reg_req,
  output logic [icpc_pkg::DATA_W-1:0] reg_rdata,
  // digitized pulse results
  input  wire icpc_pkg::icpc_pulse_s pulse_in,
  // integrator control for the next pulse, registered one cycle after the pulse index
  output logic                       integ_reversed_a,
  output logic                       integ_reversed_b,
  // combined samples
  output icpc_pkg::icpc_sample_s     sample_out
);
  import icpc_pkg::*;

  logic [DATA_W-1:0] order_a_q;
  logic [DATA_W-1:0] order_b_q;
  logic [DATA_W-1:0] count_a_q;
  logic [DATA_W-1:0] count_b_q;
  logic [DATA_W-1:0] math_q;
  logic [CNT_W-1:0]  done_a_q;
  logic [CNT_W-1:0]  done_b_q;
  logic [ACC_W-1:0]  acc_a_q;
  logic [ACC_W-1:0]  acc_b_q;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;
  logic              rev_a_q;
  logic              rev_b_q;
  icpc_sample_s      sample_d;
  icpc_sample_s      sample_q;

  function automatic logic [ACC_W-1:0] signed_step(
    input logic [ACC_W-1:0] acc,
    input logic [ADC_W-1:0] val,
    input logic             sub
  );
    logic [ACC_W-1:0] ext;
    ext = {{(ACC_W-ADC_W){1'b0}}, val};
    signed_step = sub ? acc - ext : acc + ext;
  endfunction

  // register decode
  wire logic wr_order_a = reg_req.we && reg_req.addr == OFS_ORDER_A;
  wire logic wr_order_b = reg_req.we && reg_req.addr == OFS_ORDER_B;
  wire logic wr_count_a = reg_req.we && reg_req.addr == OFS_COUNT_A;
  wire logic wr_count_b = reg_req.we && reg_req.addr == OFS_COUNT_B;
  wire logic wr_math    = reg_req.we && reg_req.addr == OFS_MATH;

  wire logic [3:0] slot_a_polarity_pattern = order_a_q[POL_LSB +: POL_W];
  wire logic [3:0] slot_b_polarity_pattern = order_b_q[POL_LSB +: POL_W];
  wire logic [1:0] slot_a_pair12_math      = math_q[M12_A_LSB +: 2];
  wire logic [1:0] slot_b_pair12_math      = math_q[M12_B_LSB +: 2];
  wire logic [1:0] slot_a_pair34_math      = math_q[M34_A_LSB +: 2];
  wire logic [1:0] slot_b_pair34_math      = math_q[M34_B_LSB +: 2];
  wire logic [CNT_W-1:0] pulses_a = count_a_q[CNT_LSB +: CNT_W];
  wire logic [CNT_W-1:0] pulses_b = count_b_q[CNT_LSB +: CNT_W];

  // modulo-four index is the low two bits of the pulses already taken
  wire logic [1:0] idx_a = done_a_q[1:0];
  wire logic [1:0] idx_b = done_b_q[1:0];

  wire logic rev_a;
  wire logic rev_b;
  wire logic sub_a;
  wire logic sub_b;

  icpc_pulse_sign u_sign_a
  (
    .pattern  (slot_a_polarity_pattern),
    .math12   (slot_a_pair12_math),
    .math34   (slot_a_pair34_math),
    .idx      (idx_a),
    .reversed (rev_a),
    .subtract (sub_a)
  );

  icpc_pulse_sign u_sign_b
  (
    .pattern  (slot_b_polarity_pattern),
    .math12   (slot_b_pair12_math),
    .math34   (slot_b_pair34_math),
    .idx      (idx_b),
    .reversed (rev_b),
    .subtract (sub_b)
  );

  wire logic take_a = pulse_in.valid && !pulse_in.slot_b;
  wire logic take_b = pulse_in.valid && pulse_in.slot_b;
  // a zero count is treated as one pulse so a sample always completes
  wire logic last_a = (done_a_q + 8'h01 >= pulses_a);
  wire logic last_b = (done_b_q + 8'h01 >= pulses_b);
  wire logic [ACC_W-1:0] next_a =
    signed_step(acc_a_q, pulse_in.value, sub_a);
  wire logic [ACC_W-1:0] next_b =
    signed_step(acc_b_q, pulse_in.value, sub_b);

  always_comb
  begin
    sample_d = '0;
    if (take_a && last_a)
    begin
      sample_d.valid  = 1'b1;
      sample_d.slot_b = 1'b0;
      sample_d.sum    = next_a;
    end
    else if (take_b && last_b)
    begin
      sample_d.valid  = 1'b1;
      sample_d.slot_b = 1'b1;
      sample_d.sum    = next_b;
    end
  end

  always_comb
  begin
    case (reg_req.addr)
      OFS_ORDER_A: rdata_d = order_a_q;
      OFS_ORDER_B: rdata_d = order_b_q;
      OFS_COUNT_A: rdata_d = count_a_q;
      OFS_COUNT_B: rdata_d = count_b_q;
      OFS_MATH:    rdata_d = math_q;
      default:     rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      order_a_q <= RST_ORDER;
      order_b_q <= RST_ORDER;
      count_a_q <= RST_COUNT;
      count_b_q <= RST_COUNT;
      math_q    <= RST_MATH;
      rdata_q   <= 16'h0000;
    end
    else
    begin
      if (wr_order_a) order_a_q <= reg_req.wdata;
      if (wr_order_b) order_b_q <= reg_req.wdata;
      if (wr_count_a) count_a_q <= reg_req.wdata;
      if (wr_count_b) count_b_q <= reg_req.wdata;
      if (wr_math)    math_q    <= reg_req.wdata;
      rdata_q <= rdata_d;
    end
  end

  // slot A pulse sequencing
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      done_a_q <= 8'h00;
      acc_a_q  <= '0;
    end
    else if (take_a)
    begin
      done_a_q <= last_a ? 8'h00 : done_a_q + 8'h01;
      acc_a_q  <= last_a ? '0 : next_a;
    end
  end

  // slot B pulse sequencing
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      done_b_q <= 8'h00;
      acc_b_q  <= '0;
    end
    else if (take_b)
    begin
      done_b_q <= last_b ? 8'h00 : done_b_q + 8'h01;
      acc_b_q  <= last_b ? '0 : next_b;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      rev_a_q  <= 1'b0;
      rev_b_q  <= 1'b0;
      sample_q <= '0;
    end
    else
    begin
      rev_a_q  <= rev_a;
      rev_b_q  <= rev_b;
      sample_q <= sample_d;
    end
  end

  assign integ_reversed_a = rev_a_q;
  assign integ_reversed_b = rev_b_q;
  assign sample_out       = sample_q;
  assign reg_rdata        = rdata_q;

endmodule // icpc_combiner

// File: core/icpc_pkg.sv
// constants, field layouts and carrier structs for the chop pulse combiner
// assumes a register port that writes 16-bit words at 8-bit addresses
package icpc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADC_W  = 14;
  localparam int unsigned ACC_W  = 24;

  localparam logic [7:0] OFS_ORDER_A = 8'h17;
  localparam logic [7:0] OFS_ORDER_B = 8'h1D;
  localparam logic [7:0] OFS_COUNT_A = 8'h31;
  localparam logic [7:0] OFS_COUNT_B = 8'h36;
  localparam logic [7:0] OFS_MATH    = 8'h58;

  localparam int unsigned POL_LSB   = 0;
  localparam int unsigned POL_W     = 4;
  localparam int unsigned CNT_LSB   = 8;
  localparam int unsigned CNT_W     = 8;
  localparam int unsigned M12_A_LSB = 1;
  localparam int unsigned M12_B_LSB = 5;
  localparam int unsigned M34_A_LSB = 8;
  localparam int unsigned M34_B_LSB = 10;

  localparam logic [15:0] RST_ORDER = 16'h0000;
  localparam logic [15:0] RST_COUNT = 16'h0100;
  localparam logic [15:0] RST_MATH  = 16'h0000;

  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } icpc_reg_req_s;

  typedef struct packed {
    logic             valid;
    logic             slot_b;
    logic [ADC_W-1:0] value;
  } icpc_pulse_s;

  typedef struct packed {
    logic             valid;
    logic             slot_b;
    logic [ACC_W-1:0] sum;
  } icpc_sample_s;

endpackage : icpc_pkg

// File: core/icpc_pulse_sign.sv
// per-pulse polarity and add/subtract decision for one slot
// assumes the pulse index is already reduced modulo four
`timescale 1ns/10ps
module icpc_pulse_sign
(
  // configuration
  input  wire logic [3:0] pattern,
  input  wire logic [1:0] math12,
  input  wire logic [1:0] math34,
  // current pulse
  input  wire logic [1:0] idx,
  // decision
  output logic            reversed,
  output logic            subtract
);
  import icpc_pkg::*;

  wire logic [1:0] pair_sel;
  // field bit 1 governs the earlier pulse of the pair, bit 0 the later
  assign reversed = pattern[idx];
  assign pair_sel = idx[1] ? math34 : math12;
  assign subtract = idx[0] ? pair_sel[0] : pair_sel[1];

endmodule // icpc_pulse_sign

// File: test/icpc_combiner_properties.sv
// port assertions for the chop pulse combiner
// assumes it is bound onto icpc_combiner
`timescale 1ns/10ps
module icpc_combiner_properties
  import icpc_pkg::*;
(
  // clock and reset
  input wire logic                    ref_clk,
  input wire logic                    resetn,
  // watched ports
  input wire icpc_pkg::icpc_reg_req_s reg_req,
  input wire logic [15:0]             reg_rdata,
  input wire icpc_pkg::icpc_pulse_s   pulse_in,
  input wire logic                    integ_reversed_a,
  input wire logic                    integ_reversed_b,
  input wire icpc_pkg::icpc_sample_s  sample_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire wr_a   = reg_req.we && reg_req.addr == OFS_ORDER_A;
  wire wr_b   = reg_req.we && reg_req.addr == OFS_ORDER_B;
  wire mapped = reg_req.addr inside {OFS_ORDER_A, OFS_ORDER_B,
                OFS_COUNT_A, OFS_COUNT_B, OFS_MATH};
  chk_reset_clean: assert property ($rose(resetn) |->
    reg_rdata == 16'h0000 && !sample_out.valid) else $error("dirty reset");
  chk_write_readback: assert property (reg_req.we && mapped
    ##1 !reg_req.we && reg_req.addr == $past(reg_req.addr)
    |=> reg_rdata == $past(reg_req.wdata, 2)) else $error("bad readback");
  chk_unmapped_zero: assert property (reg_req.addr == 8'h40
    |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  chk_sample_cause: assert property (sample_out.valid |->
    $past(pulse_in.valid) && sample_out.slot_b == $past(pulse_in.slot_b))
    else $error("sample without pulse");
  chk_pattern_a_set: assert property (
    wr_a && reg_req.wdata[3:0] == 4'hF
    ##1 !wr_a |=> integ_reversed_a) else $error("slot a not reversed");
  chk_pattern_a_clear: assert property (
    wr_a && reg_req.wdata[3:0] == 4'h0
    ##1 !wr_a |=> !integ_reversed_a) else $error("slot a reversed");
  chk_pattern_b_set: assert property (
    wr_b && reg_req.wdata[3:0] == 4'hF
    ##1 !wr_b |=> integ_reversed_b) else $error("slot b not reversed");
  chk_pattern_b_clear: assert property (
    wr_b && reg_req.wdata[3:0] == 4'h0
    ##1 !wr_b |=> !integ_reversed_b) else $error("slot b reversed");
endmodule // icpc_combiner_properties

bind icpc_combiner icpc_combiner_properties icpc_combiner_properties_i (
  .ref_clk(ref_clk), .resetn(resetn), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .pulse_in(pulse_in),
  .integ_reversed_a(integ_reversed_a), .integ_reversed_b(integ_reversed_b),
  .sample_out(sample_out));

// File: test/testbench.sv
// self-checking bench for the chop pulse combiner
// assumes the register and pulse ports declared in icpc_pkg
`timescale 1ns/10ps
module testbench;
  import icpc_pkg::*;
  logic          ref_clk = 1'b0;
  logic          resetn = 1'b0;
  icpc_reg_req_s reg_req = '0;
  icpc_pulse_s   pulse_in = '0;
  logic [15:0]   reg_rdata;
  logic          integ_reversed_a;
  logic          integ_reversed_b;
  icpc_sample_s  sample_out;
  int            failures = 0;
  int            check_count = 0;
  int            cycles = 0;
  logic [3:0]    pat_a;
  logic [3:0]    pat_b;
  logic [15:0]   math;
  logic [3:0]    pats [4] = '{4'h0, 4'h5, 4'hA, 4'hF};
  always #12.5 ref_clk = ~ref_clk;
  icpc_combiner icpc_combiner_i (.ref_clk(ref_clk), .resetn(resetn),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .pulse_in(pulse_in),
    .integ_reversed_a(integ_reversed_a),
    .integ_reversed_b(integ_reversed_b), .sample_out(sample_out));
  task check(input string what, input logic [23:0] e, input logic [23:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // idle cycle after the strobe keeps one assignment per time step
  task wr(input logic [7:0] a, input logic [15:0] d);
    reg_req = '{1'b1, a, d};
    @(negedge ref_clk);
    reg_req.we = 1'b0;
    @(negedge ref_clk);
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    reg_req = '{1'b0, a, 16'h0000};
    @(negedge ref_clk);
    check($sformatf("reg %h", a), e, reg_rdata);
  endtask
  // gap inserts an idle cycle so the lagging polarity output can be seen
  task run(input logic sb, input int n, input bit gap);
    logic [23:0] acc;
    logic [1:0]  fld;
    logic [13:0] v;
    acc = '0;
    @(negedge ref_clk);
    for (int k = 0; k < n; k++)
    begin
      fld = (k % 4 < 2) ? math[(sb ? 6 : 2) -: 2] : math[(sb ? 11 : 9) -: 2];
      v = 14'(100 + 37 * k);
      acc = fld[(k % 2) ? 0 : 1] ? acc - v : acc + v;
      if (gap)
        check("polarity", sb ? pat_b[k % 4] : pat_a[k % 4],
          sb ? integ_reversed_b : integ_reversed_a);
      pulse_in = '{1'b1, sb, v};
      @(negedge ref_clk);
      check("valid", k == n - 1, sample_out.valid);
      if (k == n - 1)
        check("sum", acc, sample_out.sum);
      // back-to-back pulses keep valid high so it is driven once per step
      if (gap || k == n - 1)
        pulse_in.valid = 1'b0;
      if (gap)
        @(negedge ref_clk);
    end
  endtask
  initial
  begin
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    rd(OFS_ORDER_A, RST_ORDER);
    rd(OFS_ORDER_B, RST_ORDER);
    rd(OFS_COUNT_A, RST_COUNT);
    rd(OFS_MATH, RST_MATH);
    wr(8'h40, 16'hFFFF);
    rd(8'h40, 16'h0000);
    // offset words must be zero in chop mode; here they are unmapped
    for (int o = 0; o < 4; o++)
    begin
      wr(8'h18 + 8'(o), 16'h0000);
      wr(8'h1E + 8'(o), 16'h0000);
    end
    rd(8'h1E, 16'h0000);
    pat_a = 4'hA;
    pat_b = 4'hA;
    math = 16'h0522;
    wr(OFS_ORDER_A, {12'h000, pat_a});
    wr(OFS_ORDER_B, {12'h000, pat_b});
    wr(OFS_MATH, math);
    wr(OFS_COUNT_A, 16'h0800);
    wr(OFS_COUNT_B, 16'h1000);
    rd(OFS_COUNT_B, 16'h1000);
    run(1'b0, 8, 1'b1);
    run(1'b1, 16, 1'b0);
    for (int c = 0; c < 4; c++)
    begin
      logic [1:0] m;
      m = 2'(c);
      pat_a = pats[c];
      pat_b = pats[3 - c];
      math = {4'h0, m, m, 1'b0, m, 2'b00, m, 1'b0};
      wr(OFS_ORDER_A, {12'h000, pat_a});
      wr(OFS_ORDER_B, {12'h000, pat_b});
      wr(OFS_MATH, math);
      wr(OFS_COUNT_A, 16'h0400);
      wr(OFS_COUNT_B, 16'h0400);
      rd(OFS_MATH, math);
      run(1'b0, 4, 1'b1);
      run(1'b1, 4, 1'b1);
    end
    wr(OFS_COUNT_A, 16'h0000);
    run(1'b0, 1, 1'b1);
    finish_test();
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      finish_test();
    end
  end
endmodule // testbench
